/* File: pcs_command_status.sv */
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_command_status (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire pcs_pkg::pcs_cfg_req_t cfg_req,
    output logic [31:0]               cfg_rdata,
    input  wire pcs_pkg::pcs_evt_t    evt,
    input  wire pcs_pkg::pcs_hit_t    hit,
    input  wire logic                 rom_decode_enable,
    input  wire logic                 dma_req,
    output logic                      io_claim,
    output logic                      mem_claim,
    output logic                      rom_claim,
    output logic                      bus_req,
    input  wire logic                 serr_n_in,
    output logic                      serr_n_out,
    output logic                      serr_oe,
    input  wire logic                 perr_n_in,
    output logic                      perr_n_out,
    output logic                      perr_oe,
    output logic                      io_space_enable,
    output logic                      memory_space_enable,
    output logic                      bus_master_enable,
    output logic                      parity_response_enable,
    output logic                      system_error_enable
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pcs_pkg::pcs_state_t st_ff;
    pcs_pkg::pcs_state_t nxt_st;

    logic        cmd_hit;
    logic [15:0] cmd_wr_bits;
    logic [15:0] sts_clr_bits;
    logic [15:0] sts_set_bits;
    logic        data_par_err;
    logic        master_dperr;
    logic        any_par_err;

    // Configuration dword holding command and status
    assign cmd_hit = (cfg_req.addr & `PCS_DWORD_MASK) == `PCS_CMD_OFFSET;

    // Byte-lane write data for the command halfword
    assign cmd_wr_bits = {cfg_req.be[1] ? cfg_req.wdata[15:8] : st_ff.cmd[15:8],
                          cfg_req.be[0] ? cfg_req.wdata[7:0]  : st_ff.cmd[7:0]};

    // Write-one-to-clear bits for the status halfword
    assign sts_clr_bits = (cfg_req.wr && cmd_hit) ?
                          ({cfg_req.be[3] ? cfg_req.wdata[31:24] : 8'h00,
                            cfg_req.be[2] ? cfg_req.wdata[23:16] : 8'h00}
                           & `PCS_STS_W1C_MASK) : 16'h0000;

    // Parity errors the device checks itself on data
    assign data_par_err = evt.slave_wr_par_err | evt.master_rd_par_err;
    // Master data parity error, own check or target report
    assign master_dperr = evt.master_rd_par_err | evt.target_perr_mwr;
    // Any source of the detected parity error flag
    assign any_par_err = evt.addr_par_err | data_par_err | evt.target_perr_mwr;

    // ------------------------------------------------------------
    // Event set terms
    // ------------------------------------------------------------
    always_comb begin
        sts_set_bits = 16'h0000;
        sts_set_bits[`PCS_STS_PERR] = any_par_err;
        sts_set_bits[`PCS_STS_SERR] = evt.addr_par_err
                                      && st_ff.cmd[`PCS_CMD_SYSTEM_ERROR_ENABLE]
                                      && st_ff.cmd[`PCS_CMD_PARITY_RESPONSE_ENABLE];
        sts_set_bits[`PCS_STS_MABORT] = evt.master_abort;
        sts_set_bits[`PCS_STS_TABORT] = evt.target_abort;
        sts_set_bits[`PCS_STS_DPERR] = master_dperr
                                       && st_ff.cmd[`PCS_CMD_PARITY_RESPONSE_ENABLE];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Only enable bits are writable, the rest stay zero
        if (cfg_req.wr && cmd_hit) begin
            nxt_st.cmd = cmd_wr_bits & `PCS_CMD_WMASK;
        end
        // Set wins over a clear in the same cycle
        nxt_st.sts = ((st_ff.sts & ~sts_clr_bits) | sts_set_bits)
                     & `PCS_STS_W1C_MASK;
        // Registered read data, zero outside this dword
        if (cfg_req.rd) begin
            nxt_st.rdata = cmd_hit ? {st_ff.sts, st_ff.cmd} : 32'h0000_0000;
        end
        // System error pin, open drain, one cycle per event
        nxt_st.serr_oe = evt.addr_par_err
                         && st_ff.cmd[`PCS_CMD_SYSTEM_ERROR_ENABLE]
                         && st_ff.cmd[`PCS_CMD_PARITY_RESPONSE_ENABLE];
        nxt_st.serr_n_out = !nxt_st.serr_oe;
        // Parity error pin only with parity response on
        nxt_st.perr_oe = data_par_err && st_ff.cmd[`PCS_CMD_PARITY_RESPONSE_ENABLE];
        nxt_st.perr_n_out = !nxt_st.perr_oe;
        // Decode gating by the space enables
        nxt_st.io_claim = hit.io && st_ff.cmd[`PCS_CMD_IO_SPACE_ENABLE];
        nxt_st.mem_claim = hit.mem && st_ff.cmd[`PCS_CMD_MEMORY_SPACE_ENABLE];
        nxt_st.rom_claim = hit.rom && rom_decode_enable
                           && st_ff.cmd[`PCS_CMD_MEMORY_SPACE_ENABLE];
        // Mastership requests need the master enable
        nxt_st.bus_req = dma_req && st_ff.cmd[`PCS_CMD_BUS_MASTER_ENABLE];
    end

    // ------------------------------------------------------------
    // Registers, cleared by hardware reset only
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff.cmd        <= `PCS_CMD_RESET;
            st_ff.sts        <= `PCS_STS_RESET;
            st_ff.rdata      <= 32'h0000_0000;
            st_ff.serr_n_out <= 1'b1;
            st_ff.serr_oe    <= 1'b0;
            st_ff.perr_n_out <= 1'b1;
            st_ff.perr_oe    <= 1'b0;
            st_ff.io_claim   <= 1'b0;
            st_ff.mem_claim  <= 1'b0;
            st_ff.rom_claim  <= 1'b0;
            st_ff.bus_req    <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cfg_rdata              = st_ff.rdata;
    assign io_claim               = st_ff.io_claim;
    assign mem_claim              = st_ff.mem_claim;
    assign rom_claim              = st_ff.rom_claim;
    assign bus_req                = st_ff.bus_req;
    assign serr_n_out             = st_ff.serr_n_out;
    assign serr_oe                = st_ff.serr_oe;
    assign perr_n_out             = st_ff.perr_n_out;
    assign perr_oe                = st_ff.perr_oe;
    assign io_space_enable        = st_ff.cmd[`PCS_CMD_IO_SPACE_ENABLE];
    assign memory_space_enable    = st_ff.cmd[`PCS_CMD_MEMORY_SPACE_ENABLE];
    assign bus_master_enable      = st_ff.cmd[`PCS_CMD_BUS_MASTER_ENABLE];
    assign parity_response_enable = st_ff.cmd[`PCS_CMD_PARITY_RESPONSE_ENABLE];
    assign system_error_enable    = st_ff.cmd[`PCS_CMD_SYSTEM_ERROR_ENABLE];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Fixed-zero command bits never become set
    property p_cmd_fixed_zero;
        (st_ff.cmd & ~`PCS_CMD_WMASK) == 16'h0000;
    endproperty
    a_cmd_fixed_zero: assert property (p_cmd_fixed_zero)
        else $error("fixed command bits not zero");

    // Command read returns zero in bits 9, 5..3
    property p_cmd_read_zero;
        cfg_req.rd && cmd_hit |=> cfg_rdata[9] == 1'b0 && cfg_rdata[5:3] == 3'h0;
    endproperty
    a_cmd_read_zero: assert property (p_cmd_read_zero)
        else $error("reserved command bits read nonzero");

    // SERR driven and flagged the cycle after an enabled address parity error
    property p_serr_drive;
        evt.addr_par_err && system_error_enable && parity_response_enable
        |=> serr_oe && !serr_n_out && st_ff.sts[`PCS_STS_SERR];
    endproperty
    a_serr_drive: assert property (p_serr_drive)
        else $error("SERR not driven on address parity error");

    // SERR never driven without both enables
    property p_serr_quiet;
        !(system_error_enable && parity_response_enable) |=> !serr_oe;
    endproperty
    a_serr_quiet: assert property (p_serr_quiet)
        else $error("SERR driven while disabled");

    // Parity response off: no PERR drive, flag still set
    property p_perr_off;
        !parity_response_enable && evt.master_rd_par_err
        |=> !perr_oe && st_ff.sts[`PCS_STS_PERR] && !$rose(st_ff.sts[`PCS_STS_DPERR]);
    endproperty
    a_perr_off: assert property (p_perr_off)
        else $error("parity reported while response disabled");

    // Parity response on: PERR driven, master error flagged
    property p_perr_on;
        parity_response_enable && evt.master_rd_par_err
        |=> perr_oe && st_ff.sts[`PCS_STS_DPERR];
    endproperty
    a_perr_on: assert property (p_perr_on)
        else $error("data parity error not reported");

    // Every parity case sets the detected flag
    property p_par_flag;
        any_par_err |=> st_ff.sts[`PCS_STS_PERR];
    endproperty
    a_par_flag: assert property (p_par_flag)
        else $error("parity flag not set");

    // Claims only while the matching enable holds
    property p_claim_gate;
        (io_claim |-> $past(io_space_enable))
        and (mem_claim |-> $past(memory_space_enable))
        and (rom_claim |-> $past(memory_space_enable) && $past(rom_decode_enable));
    endproperty
    a_claim_gate: assert property (p_claim_gate)
        else $error("cycle claimed while decode disabled");

    // Bus request needs master enable
    property p_req_gate;
        bus_req |-> $past(bus_master_enable);
    endproperty
    a_req_gate: assert property (p_req_gate)
        else $error("bus requested without master enable");

    // Write one with no event clears the master abort flag in the next cycle
    property p_w1c;
        cfg_req.wr && cmd_hit && cfg_req.be[3] && cfg_req.wdata[29] && !evt.master_abort
        |=> !st_ff.sts[`PCS_STS_MABORT];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("status flag not cleared by write one");

    // Abort events set their flags
    property p_abort;
        (evt.master_abort |=> st_ff.sts[`PCS_STS_MABORT])
        and (evt.target_abort |=> st_ff.sts[`PCS_STS_TABORT]);
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort flag not set");

    // Only the event bits of the status halfword can ever be set
    property p_sts_fixed_zero;
        (st_ff.sts & ~`PCS_STS_W1C_MASK) == 16'h0000;
    endproperty
    a_sts_fixed_zero: assert property (p_sts_fixed_zero)
        else $error("fixed status bits not zero");

    // Writing zero to a set flag leaves it set
    property p_w0_keeps;
        cfg_req.wr && cmd_hit && cfg_req.be[3] && !cfg_req.wdata[31]
        && st_ff.sts[`PCS_STS_PERR] |=> st_ff.sts[`PCS_STS_PERR];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps)
        else $error("status flag lost on write zero");

    // Signalled-error flag needs both enables
    property p_serr_flag_gate;
        !(system_error_enable && parity_response_enable) && !st_ff.sts[`PCS_STS_SERR]
        |=> !st_ff.sts[`PCS_STS_SERR];
    endproperty
    a_serr_flag_gate: assert property (p_serr_flag_gate)
        else $error("SERR flag set while disabled");

    // Master data parity flag needs parity response
    property p_dperr_gate;
        !parity_response_enable && !st_ff.sts[`PCS_STS_DPERR] |=> !st_ff.sts[`PCS_STS_DPERR];
    endproperty
    a_dperr_gate: assert property (p_dperr_gate)
        else $error("data parity flag set while response disabled");

    // No PERR drive while parity response is off
    property p_perr_quiet;
        !parity_response_enable |=> !perr_oe;
    endproperty
    a_perr_quiet: assert property (p_perr_quiet)
        else $error("PERR driven while response disabled");

    // Slave write parity error drives PERR with response on
    property p_perr_slave;
        parity_response_enable && evt.slave_wr_par_err |=> perr_oe && !perr_n_out;
    endproperty
    a_perr_slave: assert property (p_perr_slave)
        else $error("PERR not driven on slave write parity error");

    // Command zero leaves no claim and no bus request
    property p_detach;
        !io_space_enable && !memory_space_enable && !bus_master_enable
        |=> !io_claim && !mem_claim && !rom_claim && !bus_req;
    endproperty
    a_detach: assert property (p_detach)
        else $error("bus activity with command cleared");

endmodule

/* File: pcs_defines.svh */
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// ------------------------------------------------------------
// Configuration offsets
// ------------------------------------------------------------
`define PCS_CMD_OFFSET    8'h04
`define PCS_STS_OFFSET    8'h06
`define PCS_DWORD_MASK    8'hFC

// ------------------------------------------------------------
// Command field positions
// ------------------------------------------------------------
`define PCS_CMD_IO_SPACE_ENABLE      0
`define PCS_CMD_MEMORY_SPACE_ENABLE     1
`define PCS_CMD_BUS_MASTER_ENABLE      2
`define PCS_CMD_PARITY_RESPONSE_ENABLE    6
`define PCS_CMD_SYSTEM_ERROR_ENABLE    8
`define PCS_CMD_WMASK     16'h0147
`define PCS_CMD_RESET     16'h0000

// ------------------------------------------------------------
// Status field positions
// ------------------------------------------------------------
`define PCS_STS_DPERR     8
`define PCS_STS_TABORT    12
`define PCS_STS_MABORT    13
`define PCS_STS_SERR      14
`define PCS_STS_PERR      15
`define PCS_STS_W1C_MASK  16'hF100
`define PCS_STS_RESET     16'h0000

`endif

/* File: pcs_pkg.sv */
package pcs_pkg;

    // Configuration cycle request from the bus target logic
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcs_cfg_req_t;

    // Bus events seen by the master and target engines
    typedef struct packed {
        logic addr_par_err;
        logic slave_wr_par_err;
        logic master_rd_par_err;
        logic target_perr_mwr;
        logic master_abort;
        logic target_abort;
    } pcs_evt_t;

    // Address decode hits before gating
    typedef struct packed {
        logic io;
        logic mem;
        logic rom;
    } pcs_hit_t;

    // Whole register state of the block
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] sts;
        logic [31:0] rdata;
        logic        serr_n_out;
        logic        serr_oe;
        logic        perr_n_out;
        logic        perr_oe;
        logic        io_claim;
        logic        mem_claim;
        logic        rom_claim;
        logic        bus_req;
    } pcs_state_t;

endpackage

/* File: pcs_host_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host bridge model issuing configuration cycles
// ------------------------------------------------------------
module pcs_host_model (
    input  wire logic             core_clk,
    input  wire logic [31:0]      cfg_rdata,
    output pcs_pkg::pcs_cfg_req_t cfg_req
);

    // Bus starts idle with both strobes low
    initial begin
        cfg_req = '0;
    end

    // One write: strobe for one cycle, then address and data turn to garbage
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge core_clk);
        cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
        @(posedge core_clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~b, wdata: ~d};
    endtask

    // One read: data taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge core_clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: 32'hFFFF_FFFF};
        #1 d = cfg_rdata;
    endtask

    // Writes the command halfword through lanes 1..0; zero detaches the device
    task automatic set_cmd(input logic [15:0] c);
        wr(8'h04, 4'h3, {16'h0000, c});
    endtask

endmodule

/* File: pcs_command_status_tb.sv */
`timescale 1ns/1ps

module pcs_command_status_tb;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                  core_clk;
    logic                  rst_n;
    pcs_pkg::pcs_cfg_req_t cfg_req;
    logic [31:0]           cfg_rdata;
    pcs_pkg::pcs_evt_t     evt;
    pcs_pkg::pcs_hit_t     hit;
    logic                  rom_decode_enable;
    logic                  dma_req;
    logic                  io_claim;
    logic                  mem_claim;
    logic                  rom_claim;
    logic                  bus_req;
    logic                  serr_n_out;
    logic                  serr_oe;
    logic                  perr_n_out;
    logic                  perr_oe;
    logic                  io_space_enable;
    logic                  memory_space_enable;
    logic                  bus_master_enable;
    logic                  parity_response_enable;
    logic                  system_error_enable;
    logic [31:0]           rdv;
    int                    fails;
    int                    n_tests;
    int                    cyc;

    // Open-drain pins with pull-ups
    wire serr_pin = serr_oe ? serr_n_out : 1'b1;
    wire perr_pin = perr_oe ? perr_n_out : 1'b1;

    // ------------------------------------------------------------
    // Design, host model, clock and watchdog
    // ------------------------------------------------------------
    pcs_command_status dut (
        .core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .evt(evt), .hit(hit), .rom_decode_enable(rom_decode_enable), .dma_req(dma_req),
        .io_claim(io_claim), .mem_claim(mem_claim), .rom_claim(rom_claim),
        .bus_req(bus_req), .serr_n_in(serr_pin), .serr_n_out(serr_n_out),
        .serr_oe(serr_oe), .perr_n_in(perr_pin), .perr_n_out(perr_n_out),
        .perr_oe(perr_oe), .io_space_enable(io_space_enable),
        .memory_space_enable(memory_space_enable), .bus_master_enable(bus_master_enable),
        .parity_response_enable(parity_response_enable),
        .system_error_enable(system_error_enable)
    );

    pcs_host_model host (.core_clk(core_clk), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Cuts a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Program command, pulse one event, check pins and status, then clear
    task automatic ev(input logic [15:0] c, input logic [5:0] e, input logic [1:0] oe,
                      input logic [15:0] s);
        host.set_cmd(c);
        @(posedge core_clk);
        evt <= pcs_pkg::pcs_evt_t'(e);
        @(posedge core_clk);
        evt <= '0;
        #1 chk({30'h0, serr_oe, perr_oe}, {30'h0, oe});
        chk({30'h0, serr_n_out, perr_n_out}, {30'h0, ~oe});
        host.rd(8'h04, rdv);
        chk({16'h0, rdv[31:16]}, {16'h0, s});
        host.wr(8'h04, 4'hC, 32'hFFFF_0000);
        host.rd(8'h04, rdv);
        chk(rdv, {16'h0, c});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_cmd();
        host.rd(8'h04, rdv);
        chk(rdv, 32'h0);
        host.wr(8'h04, 4'hF, 32'hFFFF_FFFF);
        host.rd(8'h04, rdv);
        chk(rdv, 32'h0000_0147);
        chk({27'h0, system_error_enable, parity_response_enable, bus_master_enable,
             memory_space_enable, io_space_enable}, 32'h1F);
        host.wr(8'h04, 4'h1, 32'h0);
        host.rd(8'h04, rdv);
        chk(rdv, 32'h0000_0100);
        host.wr(8'h08, 4'hF, 32'hFFFF_FFFF);
        host.rd(8'h08, rdv);
        chk(rdv, 32'h0);
    endtask

    // All enable and ROM enable combinations with every hit raised
    task automatic s_dec();
        for (int i = 0; i < 16; i++) begin
            host.set_cmd({13'h0, i[2:0]});
            @(posedge core_clk);
            hit <= '1;
            rom_decode_enable <= i[3];
            dma_req <= 1'b1;
            @(posedge core_clk);
            #1 chk({28'h0, io_claim, mem_claim, rom_claim, bus_req},
                   {28'h0, i[0], i[1], i[1] & i[3], i[2]});
        end
        host.set_cmd(16'h0000);
        @(posedge core_clk);
        #1 chk({28'h0, io_claim, mem_claim, rom_claim, bus_req}, 32'h0);
        hit <= '0;
        dma_req <= 1'b0;
    endtask

    task automatic s_par();
        ev(16'h0140, 6'h20, 2'b10, 16'hC000);
        ev(16'h0100, 6'h20, 2'b00, 16'h8000);
        ev(16'h0040, 6'h20, 2'b00, 16'h8000);
        ev(16'h0000, 6'h10, 2'b00, 16'h8000);
        ev(16'h0040, 6'h10, 2'b01, 16'h8000);
        ev(16'h0040, 6'h08, 2'b01, 16'h8100);
        ev(16'h0040, 6'h04, 2'b00, 16'h8100);
        ev(16'h0000, 6'h08, 2'b00, 16'h8000);
    endtask

    task automatic s_abort();
        ev(16'h0004, 6'h02, 2'b00, 16'h2000);
        ev(16'h0004, 6'h01, 2'b00, 16'h1000);
        @(posedge core_clk);
        evt <= pcs_pkg::pcs_evt_t'(6'h03);
        @(posedge core_clk);
        evt <= '0;
        host.wr(8'h04, 4'hC, 32'h0);
        host.rd(8'h04, rdv);
        chk(rdv, 32'h3000_0004);
        host.wr(8'h04, 4'h8, 32'h2000_0000);
        host.rd(8'h04, rdv);
        chk(rdv, 32'h1000_0004);
        host.set_cmd(16'h0147);
        host.rd(8'h04, rdv);
        chk(rdv, 32'h1000_0147);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        host.rd(8'h04, rdv);
        chk(rdv, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fails = 0;
        n_tests = 0;
        cyc = 0;
        rst_n = 1'b0;
        evt = '0;
        hit = '0;
        rom_decode_enable = 1'b0;
        dma_req = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        s_cmd();
        s_dec();
        s_par();
        s_abort();
        close_out();
    end

endmodule
